// [include/trs_cfg.svh]
`ifndef TRS_CFG_SVH
`define TRS_CFG_SVH
// Bus selection bytes, direction bit in bit 0
`define TRS_ADDR_WR 8'h9e
`define TRS_ADDR_RD 8'h9f
`define TRS_ADDR7 7'h4f
// Command bytes
`define TRS_CMD_TEMP 8'haa
`define TRS_CMD_CLOCK 8'hc0
`define TRS_CMD_CONFIG 8'hac
// Clock register index range (seconds .. year)
`define TRS_CLK_FIRST 3'h0
`define TRS_CLK_LAST 3'h6
`define TRS_CLK_RESET_IDX 3'h0
`endif

// [include/trs_pkg.sv]
package trs_pkg;
   typedef enum logic [2:0] {
      TRS_ST_IDLE = 3'b000,
      TRS_ST_RXBYTE = 3'b001,
      TRS_ST_ACK = 3'b010,
      TRS_ST_TXBYTE = 3'b011,
      TRS_ST_MACK = 3'b100,
      TRS_ST_SKIP = 3'b101
   } trs_state_t;
   typedef enum logic [1:0] {
      TRS_SRC_NONE = 2'b00,
      TRS_SRC_TEMP = 2'b01,
      TRS_SRC_CLOCK = 2'b10,
      TRS_SRC_CONFIG = 2'b11
   } trs_src_t;
endpackage

// [include/trs_line_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Conditioned bus events passed from the line front end to the sequencer
interface trs_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic start;
   logic stop;
   modport front (output scl_rise, output scl_fall, output sda, output start, output stop);
   modport seq (input scl_rise, input scl_fall, input sda, input start, input stop);
endinterface
`default_nettype wire

// [logic/trs_line_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Two-flop synchronisers and bus condition detection
// ------------------------------------------------------------
module trs_line_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Raw bus lines
   input wire logic scl_i,
   input wire logic sda_i,
   // Conditioned events
   trs_line_if.front ev
);
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_d_reg;
   logic sda_d_reg;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         scl_d_reg <= scl_sync_reg[1];
         sda_d_reg <= sda_sync_reg[1];
      end
   end

   // Only the second stage and its delayed copy feed logic
   assign ev.scl_rise = scl_sync_reg[1] && !scl_d_reg;
   assign ev.scl_fall = !scl_sync_reg[1] && scl_d_reg;
   assign ev.sda = sda_sync_reg[1];
   assign ev.start = scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1];
   assign ev.stop = scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1];
endmodule
`default_nettype wire

// [logic/trs_read_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "trs_cfg.svh"
module trs_read_seq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Bus pins, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Data sources from the rest of the device
   input wire logic [15:0] temp_i,
   input wire logic [15:0] config_i,
   input wire logic [55:0] clock_regs_i,
   // Status
   output trs_pkg::trs_src_t src_o,
   output logic [2:0] clk_idx_o,
   output logic busy_o
);
   import trs_pkg::*;

   trs_line_if ev ();
   trs_line_sync u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ev(ev)
   );

   function automatic logic [2:0] trs_next_idx(input logic [2:0] idx);
      if (idx == `TRS_CLK_LAST)
         return `TRS_CLK_FIRST;
      else
         return idx + 3'h1;
   endfunction

   function automatic logic [7:0] trs_clk_byte(input logic [55:0] regs, input logic [2:0] idx);
      return regs[{idx, 3'h0} +: 8];
   endfunction

   trs_state_t state_reg;
   trs_src_t src_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [1:0] byte_cnt_reg;
   logic rd_mode_reg;
   logic [2:0] idx_reg;
   logic tx_second_reg;
   logic sda_drive_reg;

   // ------------------------------------------------------------
   // Byte to present next on a read
   // ------------------------------------------------------------
   logic [7:0] tx_byte;
   always_comb begin
      tx_byte = 8'hff;
      case (src_reg)
         TRS_SRC_TEMP: tx_byte = tx_second_reg ? temp_i[7:0] : temp_i[15:8];
         TRS_SRC_CONFIG: tx_byte = tx_second_reg ? config_i[7:0] : config_i[15:8];
         TRS_SRC_CLOCK: tx_byte = trs_clk_byte(clock_regs_i, idx_reg);
         default: tx_byte = 8'hff;
      endcase
   end

   // ------------------------------------------------------------
   // Protocol state machine
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_reg <= TRS_ST_IDLE;
         src_reg <= TRS_SRC_NONE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         byte_cnt_reg <= 2'h0;
         rd_mode_reg <= 1'b0;
         idx_reg <= `TRS_CLK_RESET_IDX;
         tx_second_reg <= 1'b0;
         sda_drive_reg <= 1'b0;
      end else if (ev.start) begin
         // Repeated start keeps the selected source and index
         state_reg <= TRS_ST_RXBYTE;
         bit_cnt_reg <= 4'h0;
         byte_cnt_reg <= 2'h0;
         tx_second_reg <= 1'b0;
         sda_drive_reg <= 1'b0;
      end else if (ev.stop) begin
         state_reg <= TRS_ST_IDLE;
         sda_drive_reg <= 1'b0;
      end else begin
         case (state_reg)
            TRS_ST_IDLE: begin
               sda_drive_reg <= 1'b0;
            end
            TRS_ST_RXBYTE: begin
               if (ev.scl_rise) begin
                  shift_reg <= {shift_reg[6:0], ev.sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (ev.scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h0;
                  if (byte_cnt_reg == 2'h0) begin
                     if (shift_reg[7:1] == `TRS_ADDR7) begin
                        rd_mode_reg <= shift_reg[0];
                        sda_drive_reg <= 1'b1;
                        state_reg <= TRS_ST_ACK;
                     end else begin
                        state_reg <= TRS_ST_SKIP;
                     end
                  end else begin
                     sda_drive_reg <= 1'b1;
                     state_reg <= TRS_ST_ACK;
                     if (byte_cnt_reg == 2'h1) begin
                        // Unknown commands are acknowledged but return idle bytes
                        case (shift_reg)
                           `TRS_CMD_TEMP: src_reg <= TRS_SRC_TEMP;
                           `TRS_CMD_CLOCK: src_reg <= TRS_SRC_CLOCK;
                           `TRS_CMD_CONFIG: src_reg <= TRS_SRC_CONFIG;
                           default: src_reg <= TRS_SRC_NONE;
                        endcase
                     end else if (byte_cnt_reg == 2'h2 && src_reg == TRS_SRC_CLOCK) begin
                        // Out of range index folds onto seconds
                        idx_reg <= (shift_reg > {5'h00, `TRS_CLK_LAST}) ?
                                   `TRS_CLK_FIRST : shift_reg[2:0];
                     end
                  end
                  if (byte_cnt_reg != 2'h3)
                     byte_cnt_reg <= byte_cnt_reg + 2'h1;
               end
            end
            TRS_ST_ACK: begin
               // Acknowledge held low through one full clock pulse
               if (ev.scl_fall) begin
                  if (rd_mode_reg) begin
                     shift_reg <= tx_byte;
                     sda_drive_reg <= !tx_byte[7];
                     bit_cnt_reg <= 4'h1;
                     state_reg <= TRS_ST_TXBYTE;
                  end else begin
                     sda_drive_reg <= 1'b0;
                     state_reg <= TRS_ST_RXBYTE;
                  end
               end
            end
            TRS_ST_TXBYTE: begin
               if (ev.scl_fall) begin
                  if (bit_cnt_reg == 4'h8) begin
                     sda_drive_reg <= 1'b0;
                     state_reg <= TRS_ST_MACK;
                  end else begin
                     sda_drive_reg <= !shift_reg[6];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            TRS_ST_MACK: begin
               if (ev.scl_rise) begin
                  if (ev.sda) begin
                     // Not-acknowledge ends the read phase; wait for start or stop
                     state_reg <= TRS_ST_SKIP;
                  end else begin
                     tx_second_reg <= 1'b1;
                     if (src_reg == TRS_SRC_CLOCK)
                        idx_reg <= trs_next_idx(idx_reg);
                     state_reg <= TRS_ST_ACK;
                  end
               end
            end
            TRS_ST_SKIP: begin
               sda_drive_reg <= 1'b0;
            end
            default: begin
               state_reg <= TRS_ST_IDLE;
               sda_drive_reg <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_drive_reg;
   assign src_o = src_reg;
   assign clk_idx_o = idx_reg;
   assign busy_o = (state_reg != TRS_ST_IDLE) && (state_reg != TRS_ST_SKIP);
endmodule
`default_nettype wire

// [verif/trs_read_seq_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module trs_read_seq_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Watched ports
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [2:0] clk_idx_o,
   input wire logic busy_o,
   input wire trs_pkg::trs_src_t src_o
);
   import trs_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // An ack or data bit must outlast the rest of the low half of SCL
   sequence s_drive_held;
      sda_oe_o [*8];
   endsequence
   // Reset leaves the line released and the source and index cleared
   sequence s_reset_state;
      !sda_oe_o && !busy_o && clk_idx_o == 3'h0 && src_o == TRS_SRC_NONE;
   endsequence
   a_reset_clear: assert property (disable iff (1'b0) !rstn_i |=> s_reset_state)
      else $error("state not cleared by reset");
   a_oe_in_xfer: assert property (sda_oe_o |-> busy_o)
      else $error("data line driven outside a transfer");
   a_drive_low: assert property (sda_oe_o |-> !sda_o)
      else $error("data line driven high");
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line changed while clock high");
   a_ack_held: assert property ($rose(sda_oe_o) |-> s_drive_held)
      else $error("driven bit released too early");
   a_idx_range: assert property (clk_idx_o <= 3'h6)
      else $error("clock index past year");
   a_idx_quiet: assert property (!busy_o |=> $stable(clk_idx_o))
      else $error("clock index moved while idle");
   a_src_quiet: assert property (!busy_o |=> $stable(src_o))
      else $error("source moved while idle");
endmodule
bind trs_read_seq trs_read_seq_chk i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .clk_idx_o(clk_idx_o), .busy_o(busy_o), .src_o(src_o));
`default_nettype wire

// [verif/trs_mst.sv]
`timescale 1ns/1ps
`default_nettype none
// Bus master model: half period 10 clk, data changes 2 clk after SCL falls
module trs_mst (
   // Clock
   input wire logic clk_i,
   // Bus, data line pulled up
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic hp(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic start();
      sda_oe_o <= 1'b0;
      hp(10);
      scl_o <= 1'b1;
      hp(10);
      sda_oe_o <= 1'b1;
      hp(10);
      scl_o <= 1'b0;
      hp(2);
   endtask
   task automatic stop();
      sda_oe_o <= 1'b1;
      hp(10);
      scl_o <= 1'b1;
      hp(10);
      sda_oe_o <= 1'b0;
      hp(10);
   endtask
   // Send 0xff to read; ninth bit 0 acks a read byte, 1 ends it
   task automatic xb(input logic [7:0] d, input logic n9, output logic [7:0] q,
      output logic s9);
      logic [8:0] v;
      v = {d, n9};
      for (int i = 8; i >= 0; i--) begin
         sda_oe_o <= ~v[i];
         hp(10);
         scl_o <= 1'b1;
         hp(10);
         v[i] = sda_i;
         scl_o <= 1'b0;
         hp(2);
      end
      q = v[8:1];
      s9 = v[0];
   endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import trs_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] temp_i = 16'h0000;
   logic [15:0] config_i = 16'h0000;
   logic [55:0] clock_regs_i = 56'h66554433221100;
   logic m_oe, d_oe, d_out, busy, a;
   logic [7:0] q;
   logic [2:0] idx;
   trs_src_t src;
   wire logic scl;
   wire logic sda;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   always #5 clk_i = ~clk_i;
   assign sda = ~(m_oe | (d_oe & ~d_out));
   trs_mst i_mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   trs_read_seq i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(d_out), .sda_oe_o(d_oe), .temp_i(temp_i), .config_i(config_i),
      .clock_regs_i(clock_regs_i), .src_o(src), .clk_idx_o(idx), .busy_o(busy));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      i_mst.xb(d, 1'b1, q, a);
      chk("ack", 8'h00, {7'h0, a});
   endtask
   task automatic rd(input logic [7:0] e, input logic more);
      i_mst.xb(8'hff, ~more, q, a);
      chk("data", e, q);
   endtask
   task automatic sel(input logic [7:0] cmd, input logic rsel);
      i_mst.start();
      wr(8'h9e);
      wr(cmd);
      if (rsel) begin
         i_mst.start();
         wr(8'h9f);
      end
   endtask
   task automatic t_temp();
      temp_i <= 16'h5a3c;
      sel(8'haa, 1'b1);
      rd(8'h5a, 1'b1);
      rd(8'h3c, 1'b0);
      chk("src", 8'h01, {6'h0, src});
      i_mst.start();
      wr(8'h9f);
      rd(8'h5a, 1'b0);
      i_mst.stop();
      $display("temperature read done");
   endtask
   task automatic t_clock(input logic [2:0] s, input int n);
      sel(8'hc0, 1'b0);
      wr({5'h0, s});
      i_mst.start();
      wr(8'h9f);
      for (int k = 0; k < n; k++)
         rd(8'(17 * ((s + k) % 7)), k < n - 1);
      chk("index", 8'((s + n - 1) % 7), {5'h0, idx});
      i_mst.stop();
      $display("clock read from %0d done", s);
   endtask
   task automatic t_cfg();
      config_i <= 16'hc381;
      sel(8'hac, 1'b1);
      chk("busy", 8'h01, {7'h0, busy});
      rd(8'hc3, 1'b1);
      rd(8'h81, 1'b0);
      i_mst.stop();
      chk("busy", 8'h00, {7'h0, busy});
      $display("configuration read done");
   endtask
   // Unknown command reads idle bytes; an index past year folds onto seconds
   task automatic t_unknown();
      sel(8'h55, 1'b1);
      rd(8'hff, 1'b0);
      chk("src", 8'h00, {6'h0, src});
      sel(8'hc0, 1'b0);
      wr(8'h09);
      i_mst.start();
      wr(8'h9f);
      rd(8'h00, 1'b1);
      rd(8'h11, 1'b0);
      chk("index", 8'h01, {5'h0, idx});
      i_mst.stop();
      $display("unknown command and index done");
   endtask
   // Reset in mid-run clears source and index left by the last read
   task automatic t_reset();
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("src", 8'h00, {6'h0, src});
      chk("index", 8'h00, {5'h0, idx});
      chk("busy", 8'h00, {7'h0, busy});
      $display("mid-run reset done");
   endtask
   task automatic t_foreign();
      i_mst.start();
      i_mst.xb(8'h90, 1'b1, q, a);
      chk("nack", 8'h01, {7'h0, a});
      chk("busy", 8'h00, {7'h0, busy});
      i_mst.stop();
      $display("foreign address done");
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      t_temp();
      t_clock(3'h1, 6);
      t_clock(3'h5, 4);
      t_cfg();
      t_unknown();
      t_reset();
      t_foreign();
      end_sim();
   end
   // A full run takes about 8800 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         end_sim();
      end
   end
endmodule
`default_nettype wire
